// ### psc_pkg.sv
// Package with register map, field layout, codes and timing for the pressure satellite block.
package psc_pkg;
	localparam logic [7:0] ADDR_SRC0 = 8'h1a;
	localparam logic [7:0] ADDR_SRC1 = 8'h1b;
	localparam logic [7:0] ADDR_SPC = 8'h1c;
	localparam logic [7:0] ADDR_KIND = 8'h1d;
	localparam logic [7:0] ADDR_STSEL = 8'h1e;
	localparam logic [7:0] ADDR_STAT = 8'h1f;
	localparam logic [7:0] ADDR_INIT = 8'h20;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int SRC_EN_BIT = 7;
	localparam int INIT_DONE_BIT = 0;
	localparam logic [1:0] KIND_REL = 2'h0;
	localparam logic [1:0] KIND_ABS = 2'h1;
	localparam logic [1:0] KIND_FILT = 2'h2;
	localparam logic [1:0] KIND_TEMP = 2'h3;
	localparam logic [3:0] FLT_370_2P = 4'h0;
	localparam logic [3:0] FLT_400_3P = 4'h1;
	localparam logic [3:0] FLT_1000_4P = 4'h2;
	localparam logic [3:0] FLT_800_4P = 4'h3;
	localparam logic [1:0] RANGE_B = 2'h0;
	localparam logic [1:0] RANGE_C = 2'h1;
	localparam logic [3:0] ST_OFF = 4'h0;
	localparam logic [3:0] ST_CM = 4'h1;
	localparam logic [3:0] ST_DIG1 = 4'hc;
	localparam logic [3:0] ST_DIG2 = 4'hd;
	localparam logic [3:0] ST_DIG3 = 4'he;
	localparam logic [3:0] ST_DIG4 = 4'hf;
	localparam logic [15:0] DIG1_WORD = 16'h8171;
	localparam logic [15:0] DIG2_WORD = 16'h6c95;
	localparam logic [15:0] DIG3_WORD = 16'h807a;
	localparam logic [15:0] DIG4_WORD = 16'h78ac;
	localparam int CLK_MHZ = 125;
	localparam int SELFTEST_PERIOD_US = 1000;
	localparam int SELFTEST_PERIOD_CYC = SELFTEST_PERIOD_US * CLK_MHZ;
	localparam logic [15:0] CM_LIMIT = 16'h0800;
	localparam logic [7:0] CRC_POLY = 8'h2f;
	localparam logic [7:0] CRC_SEED = 8'hff;

	typedef struct packed {
		logic global_cmd;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} psc_crm_cmd_t;

	typedef struct packed {
		logic [3:0] source_id;
		logic [1:0] source_count;
		logic [3:0] status;
		logic [9:0] value;
		logic [7:0] crc;
	} psc_frame_t;

	function automatic logic [7:0] psc_crc(input logic [19:0] data);
		logic [7:0] c;
		logic fb;
		c = CRC_SEED;
		for (int i = 19; i >= 0; i--) begin
			fb = c[7] ^ data[i];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction : psc_crc
endpackage : psc_pkg

// ### psc_satellite.sv
// Configuration, self-test and mode-change logic of the pressure satellite.
// Operation
// - Registers 1A and 1B configure sources 0 and 1; bit 7 enables.
// - Two sources, each with own enable, identifier and data kind.
// - Four-bit filter select picks one of four low-pass filters.
// - Two-bit range select picks range B or range C.
// - Per-source data kind selects relative, absolute, filtered or temperature.
// - Common-mode test sets running, clears fail, compares against a limit.
// - Common-mode result above the limit sets the fail flag.
// - Common-mode test repeats every self-test period while selected.
// - After disable, final result within one period; running held until then.
// - Digital self-test injects a constant in place of converter output.
// - Digital codes C to F give fixed output words for both ranges.
// - Fixed digital outputs apply only when data kind is absolute pressure.
// - Any digital self-test code sets the running flag.
// - PDCM entered by init-done write or global enter command.
// - At most one response per CRM command, none for a global command.
// - Broadcast read in PDCM triggers the satellite's frames.
module psc_satellite #(
	parameter int SELFTEST_PERIOD_CYC = psc_pkg::SELFTEST_PERIOD_CYC,
	parameter logic [15:0] CM_LIMIT = psc_pkg::CM_LIMIT
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic crm_valid,
	input wire psc_pkg::psc_crm_cmd_t crm_cmd,
	input wire logic enter_pdcm,
	input wire logic brc,
	input wire logic [15:0] rel_pressure,
	input wire logic [15:0] absolute_pressure,
	input wire logic [15:0] filt_pressure,
	input wire logic [15:0] temperature,
	input wire logic [15:0] cm_value,
	output logic rsp_valid_q,
	output logic [7:0] rsp_data_q,
	output logic frame_valid_q,
	output psc_pkg::psc_frame_t frame_q,
	output logic pdcm_mode_q,
	output logic [3:0] filter_select_q,
	output logic [1:0] range_select_q,
	output logic selftest_running_q,
	output logic selftest_fail_q
);
	typedef enum logic [1:0] {ST_IDLE, ST_CM_RUN, ST_CM_FINAL, ST_DIG} psc_st_state_t;

	logic [7:0] src0_q, src0_d, src1_q, src1_d;
	logic [3:0] kind_q, kind_d, stsel_q, stsel_d;
	logic [3:0] filter_d;
	logic [1:0] range_d;
	logic pdcm_d, rsp_valid_d;
	logic [7:0] rsp_data_d;
	logic [7:0] rd_byte;
	logic is_wr;

	psc_st_state_t st_q, st_d;
	logic [31:0] tmr_q, tmr_d;
	logic [31:0] fin_q, fin_d;
	logic tick;
	logic running_d, fail_d;
	logic dig_sel;

	logic [15:0] word_q [2];
	logic [15:0] word_d [2];
	logic [1:0] cnt_q [2];
	logic [1:0] cnt_d [2];
	logic pend_q, pend_d, fv_d;
	psc_pkg::psc_frame_t frame_d;

	assign is_wr = crm_valid && !crm_cmd.global_cmd && crm_cmd.write && !pdcm_mode_q;
	assign dig_sel = stsel_q >= psc_pkg::ST_DIG1;
	assign tick = tmr_q == 32'(SELFTEST_PERIOD_CYC - 1);

	// Register read view; unmapped addresses read as zero.
	always_comb begin
		rd_byte = psc_pkg::RST_BYTE;
		if (crm_cmd.addr == psc_pkg::ADDR_SRC0) begin
			rd_byte = src0_d;
		end else if (crm_cmd.addr == psc_pkg::ADDR_SRC1) begin
			rd_byte = src1_d;
		end else if (crm_cmd.addr == psc_pkg::ADDR_SPC) begin
			rd_byte = {2'h0, range_d, filter_d};
		end else if (crm_cmd.addr == psc_pkg::ADDR_KIND) begin
			rd_byte = {4'h0, kind_d};
		end else if (crm_cmd.addr == psc_pkg::ADDR_STSEL) begin
			rd_byte = {4'h0, stsel_d};
		end else if (crm_cmd.addr == psc_pkg::ADDR_STAT) begin
			rd_byte = {6'h00, selftest_fail_q, selftest_running_q};
		end
	end

	// CRM register file and mode change.
	always_comb begin
		src0_d = src0_q;
		src1_d = src1_q;
		filter_d = filter_select_q;
		range_d = range_select_q;
		kind_d = kind_q;
		stsel_d = stsel_q;
		pdcm_d = pdcm_mode_q;
		if (is_wr) begin
			if (crm_cmd.addr == psc_pkg::ADDR_SRC0) begin
				src0_d = crm_cmd.wdata;
			end else if (crm_cmd.addr == psc_pkg::ADDR_SRC1) begin
				src1_d = {crm_cmd.wdata[7], 3'h0, crm_cmd.wdata[3:0]};
			end else if (crm_cmd.addr == psc_pkg::ADDR_SPC) begin
				filter_d = crm_cmd.wdata[3:0];
				range_d = crm_cmd.wdata[5:4];
			end else if (crm_cmd.addr == psc_pkg::ADDR_KIND) begin
				kind_d = crm_cmd.wdata[3:0];
			end else if (crm_cmd.addr == psc_pkg::ADDR_STSEL) begin
				stsel_d = crm_cmd.wdata[3:0];
			end else if (crm_cmd.addr == psc_pkg::ADDR_INIT) begin
				pdcm_d = crm_cmd.wdata[psc_pkg::INIT_DONE_BIT];
			end
		end
		if (enter_pdcm) begin
			pdcm_d = 1'b1;
		end
	end

	// One response per addressed command outside PDCM, none for global commands or in PDCM.
	always_comb begin
		rsp_valid_d = crm_valid && !crm_cmd.global_cmd && !pdcm_mode_q;
		rsp_data_d = rsp_valid_d ? rd_byte : psc_pkg::RST_BYTE;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			src0_q <= psc_pkg::RST_BYTE;
			src1_q <= psc_pkg::RST_BYTE;
			filter_select_q <= psc_pkg::FLT_370_2P;
			range_select_q <= psc_pkg::RANGE_B;
			kind_q <= 4'h0;
			stsel_q <= psc_pkg::ST_OFF;
			pdcm_mode_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= psc_pkg::RST_BYTE;
		end else begin
			src0_q <= src0_d;
			src1_q <= src1_d;
			filter_select_q <= filter_d;
			range_select_q <= range_d;
			kind_q <= kind_d;
			stsel_q <= stsel_d;
			pdcm_mode_q <= pdcm_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
		end
	end

	// Self-test sequencer with its period timer.
	always_comb begin
		st_d = st_q;
		tmr_d = tick ? 32'h0 : tmr_q + 32'h1;
		running_d = selftest_running_q;
		fail_d = selftest_fail_q;
		fin_d = (st_q == ST_CM_FINAL) ? fin_q + 32'h1 : 32'h0;
		case (st_q)
			ST_IDLE, ST_DIG: begin
				running_d = 1'b0;
				st_d = ST_IDLE;
				if (stsel_q == psc_pkg::ST_CM) begin
					st_d = ST_CM_RUN;
					running_d = 1'b1;
					fail_d = 1'b0;
					tmr_d = 32'h0;
				end else if (dig_sel) begin
					st_d = ST_DIG;
					running_d = 1'b1;
				end
			end
			ST_CM_RUN: begin
				if (tick && cm_value > CM_LIMIT) begin
					fail_d = 1'b1;
				end
				if (stsel_q != psc_pkg::ST_CM) begin
					st_d = ST_CM_FINAL;
				end
			end
			ST_CM_FINAL: begin
				if (tick) begin
					fail_d = selftest_fail_q || cm_value > CM_LIMIT;
					running_d = 1'b0;
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			tmr_q <= 32'h0;
			fin_q <= 32'h0;
			selftest_running_q <= 1'b0;
			selftest_fail_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			fin_q <= fin_d;
			selftest_running_q <= running_d;
			selftest_fail_q <= fail_d;
		end
	end

	// Per-source output word, with digital self-test injection.
	generate
		for (genvar s = 0; s < 2; s++) begin : g_src
			always_comb begin
				case (kind_q[2*s +: 2])
					psc_pkg::KIND_REL: word_d[s] = rel_pressure;
					psc_pkg::KIND_ABS: word_d[s] = absolute_pressure;
					psc_pkg::KIND_FILT: word_d[s] = filt_pressure;
					default: word_d[s] = temperature;
				endcase
				if (dig_sel && kind_q[2*s +: 2] == psc_pkg::KIND_ABS) begin
					case (stsel_q)
						psc_pkg::ST_DIG1: word_d[s] = psc_pkg::DIG1_WORD;
						psc_pkg::ST_DIG2: word_d[s] = psc_pkg::DIG2_WORD;
						psc_pkg::ST_DIG3: word_d[s] = psc_pkg::DIG3_WORD;
						default: word_d[s] = psc_pkg::DIG4_WORD;
					endcase
				end
			end
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					word_q[s] <= 16'h0000;
				end else begin
					word_q[s] <= word_d[s];
				end
			end
		end
	endgenerate

	// PDCM frame builder: source 0 first, source 1 one cycle later, or at once if source 0 is disabled.
	function automatic psc_pkg::psc_frame_t build(input logic [7:0] cfg, input logic [1:0] cnt,
		input logic [15:0] word);
		psc_pkg::psc_frame_t f;
		f.source_id = cfg[3:0];
		f.source_count = cnt;
		f.status = {pdcm_mode_q, selftest_running_q, selftest_fail_q, 1'b0};
		f.value = word[15:6];
		f.crc = psc_pkg::psc_crc({f.source_id, f.source_count, f.status, f.value});
		return f;
	endfunction : build

	always_comb begin
		fv_d = 1'b0;
		pend_d = 1'b0;
		frame_d = frame_q;
		cnt_d[0] = cnt_q[0];
		cnt_d[1] = cnt_q[1];
		if (pend_q) begin
			fv_d = 1'b1;
			frame_d = build(src1_q, cnt_q[1], word_q[1]);
			cnt_d[1] = cnt_q[1] + 2'h1;
		end else if (brc && pdcm_mode_q) begin
			if (src0_q[psc_pkg::SRC_EN_BIT]) begin
				fv_d = 1'b1;
				frame_d = build(src0_q, cnt_q[0], word_q[0]);
				cnt_d[0] = cnt_q[0] + 2'h1;
				pend_d = src1_q[psc_pkg::SRC_EN_BIT];
			end else if (src1_q[psc_pkg::SRC_EN_BIT]) begin
				fv_d = 1'b1;
				frame_d = build(src1_q, cnt_q[1], word_q[1]);
				cnt_d[1] = cnt_q[1] + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			frame_valid_q <= 1'b0;
			frame_q <= '0;
			pend_q <= 1'b0;
			cnt_q[0] <= 2'h0;
			cnt_q[1] <= 2'h0;
		end else begin
			frame_valid_q <= fv_d;
			frame_q <= frame_d;
			pend_q <= pend_d;
			cnt_q[0] <= cnt_d[0];
			cnt_q[1] <= cnt_d[1];
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_src0_write: assert property (is_wr && crm_cmd.addr == psc_pkg::ADDR_SRC0 |=>
		src0_q == $past(crm_cmd.wdata)) else $error("source 0 register not written");
	a_global_silent: assert property (crm_valid && crm_cmd.global_cmd |=>
		!rsp_valid_q) else $error("response sent to global command");
	a_cmd_answered: assert property (crm_valid && !crm_cmd.global_cmd && !pdcm_mode_q |=>
		rsp_valid_q && rsp_data_q == $past(rd_byte)) else $error("command not answered");
	a_pdcm_entry: assert property (enter_pdcm |=> pdcm_mode_q)
		else $error("global enter command did not enter PDCM");
	a_cm_start: assert property (st_q == ST_IDLE && stsel_q == psc_pkg::ST_CM |=>
		selftest_running_q && !selftest_fail_q) else $error("common-mode start flags wrong");
	a_cm_fail_set: assert property (st_q == ST_CM_RUN && tick && cm_value > CM_LIMIT |=>
		selftest_fail_q) else $error("fail flag not set on limit");
	a_cm_repeat: assert property (st_q == ST_CM_RUN && stsel_q == psc_pkg::ST_CM |=>
		st_q == ST_CM_RUN && selftest_running_q) else $error("common-mode test stopped");
	a_cm_final: assert property (st_q == ST_CM_FINAL |-> selftest_running_q)
		else $error("running dropped before final result");
	a_cm_final_bound: assert property (st_q == ST_CM_FINAL |->
		fin_q < 32'(SELFTEST_PERIOD_CYC)) else $error("final result later than one period");
	a_dig_running: assert property (st_q == ST_IDLE && dig_sel |=>
		selftest_running_q) else $error("digital self-test not flagged");
	a_dig_word: assert property (stsel_q == psc_pkg::ST_DIG4 &&
		kind_q[1:0] == psc_pkg::KIND_ABS |=> word_q[0] == psc_pkg::DIG4_WORD)
		else $error("digital self-test word wrong");
	a_frame_crc: assert property (frame_valid_q |->
		frame_q.crc == psc_pkg::psc_crc({frame_q.source_id, frame_q.source_count,
		frame_q.status, frame_q.value})) else $error("frame check field wrong");
	a_frame_pair: assert property (brc && pdcm_mode_q && !pend_q &&
		src0_q[psc_pkg::SRC_EN_BIT] && src1_q[psc_pkg::SRC_EN_BIT]
		|=> frame_valid_q ##1 frame_valid_q && frame_q.source_id == $past(src1_q[3:0]))
		else $error("second source frame missing");

	c_cm_done: cover property (st_q == ST_CM_FINAL ##1 st_q == ST_IDLE);
	c_cm_fail: cover property (st_q == ST_CM_RUN && tick && cm_value > CM_LIMIT);
	c_dig_test: cover property (st_q == ST_DIG);
	c_two_frames: cover property (frame_valid_q ##1 frame_valid_q);
endmodule : psc_satellite

// ### psc_ctl_model.sv
// Bus controller model that issues CRM commands, global enter commands and broadcast reads.
module psc_ctl_model (
	input wire logic clk_sys,
	output psc_pkg::psc_crm_cmd_t crm_cmd,
	output logic crm_valid,
	output logic enter_pdcm,
	output logic brc,
	input wire logic rsp_valid_q,
	input wire logic [7:0] rsp_data_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic got;
	logic [7:0] rsp;

	initial begin
		crm_valid = 1'b0;
		crm_cmd = '0;
		enter_pdcm = 1'b0;
		brc = 1'b0;
	end

	// One command for one edge; the answer is taken in the cycle after that edge.
	task automatic crm(input logic glb, input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		crm_valid = 1'b1;
		crm_cmd = '{global_cmd: glb, write: wr, addr: a, wdata: d};
		@(negedge clk_sys);
		crm_valid = 1'b0;
		crm_cmd = ~crm_cmd;
		got = rsp_valid_q;
		rsp = rsp_data_q;
	endtask : crm

	// A one-cycle global enter command or broadcast read.
	task automatic strobe(input logic is_brc);
		@(negedge clk_sys);
		enter_pdcm = !is_brc;
		brc = is_brc;
		@(negedge clk_sys);
		enter_pdcm = 1'b0;
		brc = 1'b0;
	endtask : strobe
endmodule : psc_ctl_model

// ### pressure_satellite_config_selftest_test.sv
// Self-checking testbench of the pressure satellite block.
module pressure_satellite_config_selftest_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 16;
	localparam logic [15:0] DW [4] = '{psc_pkg::DIG1_WORD, psc_pkg::DIG2_WORD,
		psc_pkg::DIG3_WORD, psc_pkg::DIG4_WORD};
	logic clk_sys;
	logic sys_rst;
	logic crm_valid;
	psc_pkg::psc_crm_cmd_t crm_cmd;
	logic enter_pdcm;
	logic brc;
	logic [15:0] rel_pressure;
	logic [15:0] absolute_pressure;
	logic [15:0] filt_pressure;
	logic [15:0] temperature;
	logic [15:0] cm_value;
	logic rsp_valid_q;
	logic [7:0] rsp_data_q;
	logic frame_valid_q;
	psc_pkg::psc_frame_t frame_q;
	logic pdcm_mode_q;
	logic [3:0] filter_select_q;
	logic [1:0] range_select_q;
	logic selftest_running_q;
	logic selftest_fail_q;
	int err_total;
	int checked;
	int cycles;
	logic [31:0] seed;

	psc_satellite #(.SELFTEST_PERIOD_CYC(PER)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.crm_valid(crm_valid), .crm_cmd(crm_cmd), .enter_pdcm(enter_pdcm), .brc(brc),
		.rel_pressure(rel_pressure), .absolute_pressure(absolute_pressure),
		.filt_pressure(filt_pressure), .temperature(temperature), .cm_value(cm_value),
		.rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .frame_valid_q(frame_valid_q),
		.frame_q(frame_q), .pdcm_mode_q(pdcm_mode_q), .filter_select_q(filter_select_q),
		.range_select_q(range_select_q), .selftest_running_q(selftest_running_q),
		.selftest_fail_q(selftest_fail_q));

	psc_ctl_model u_ctl (.clk_sys(clk_sys), .crm_cmd(crm_cmd), .crm_valid(crm_valid),
		.enter_pdcm(enter_pdcm), .brc(brc), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [27:0] frame(input logic [3:0] id, input logic [1:0] cnt,
		input logic [3:0] st, input logic [15:0] w);
		logic [19:0] h;
		logic [7:0] c;
		h = {id, cnt, st, w[15:6]};
		c = psc_pkg::CRC_SEED;
		for (int i = 19; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? psc_pkg::CRC_POLY : 8'h00);
		end
		return {h, c};
	endfunction : frame

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic results();
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	task automatic do_reset();
		@(negedge clk_sys);
		sys_rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
	endtask : do_reset

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] want);
		u_ctl.crm(1'b0, wr, a, d);
		check(u_ctl.got, 1'b1);
		check(u_ctl.rsp, want);
	endtask : xfer

	task automatic stir();
		rel_pressure = 16'(rnd());
		absolute_pressure = 16'(rnd());
		filt_pressure = 16'(rnd());
		temperature = 16'(rnd());
	endtask : stir

	task automatic wait_idle();
		for (int n = 0; n < PER + 4 && selftest_running_q === 1'b1; n++) @(negedge clk_sys);
		check(selftest_running_q, 1'b0);
	endtask : wait_idle

	initial begin
		logic [7:0] v;
		logic [3:0] id0;
		logic [3:0] id1;
		logic [15:0] want1;
		err_total = 0;
		checked = 0;
		cycles = 0;
		seed = 32'd10;
		sys_rst = 1'b1;
		cm_value = 16'h0800;
		stir();
		do_reset();
		for (int a = 8'h1a; a <= 8'h1f; a++) xfer(1'b0, 8'(a), 8'h00, 8'h00);
		check({pdcm_mode_q, filter_select_q, range_select_q}, 7'h00);
		repeat (8) begin
			v = 8'(rnd());
			xfer(1'b1, psc_pkg::ADDR_SRC0, v, v);
			xfer(1'b1, psc_pkg::ADDR_SRC1, v, v & 8'h8f);
		end
		xfer(1'b0, 8'h33, 8'h00, 8'h00);
		u_ctl.crm(1'b1, 1'b0, psc_pkg::ADDR_SRC0, 8'h00);
		check(u_ctl.got, 1'b0);
		for (int i = 0; i < 16; i++) begin
			xfer(1'b1, psc_pkg::ADDR_SPC, {2'b00, 2'(i), 4'(i)}, {2'b00, 2'(i), 4'(i)});
			@(negedge clk_sys);
			check({range_select_q, filter_select_q}, {2'(i), 4'(i)});
		end
		xfer(1'b1, psc_pkg::ADDR_STSEL, 8'(psc_pkg::ST_CM), 8'(psc_pkg::ST_CM));
		@(negedge clk_sys);
		check({selftest_running_q, selftest_fail_q}, 2'b10);
		repeat (2 * PER) @(negedge clk_sys);
		check(selftest_fail_q, 1'b0);
		xfer(1'b0, psc_pkg::ADDR_STAT, 8'h00, 8'h01);
		cm_value = 16'h0801;
		xfer(1'b1, psc_pkg::ADDR_STSEL, 8'(psc_pkg::ST_OFF), 8'(psc_pkg::ST_OFF));
		wait_idle();
		check(selftest_fail_q, 1'b1);
		cm_value = 16'h0100;
		// The failed common-mode test is repeated once.
		xfer(1'b1, psc_pkg::ADDR_STSEL, 8'(psc_pkg::ST_CM), 8'(psc_pkg::ST_CM));
		@(negedge clk_sys);
		check({selftest_running_q, selftest_fail_q}, 2'b10);
		repeat (PER + 2) @(negedge clk_sys);
		check(selftest_fail_q, 1'b0);
		cm_value = 16'hffff;
		repeat (PER + 2) @(negedge clk_sys);
		check(selftest_fail_q, 1'b1);
		xfer(1'b1, psc_pkg::ADDR_STSEL, 8'(psc_pkg::ST_OFF), 8'(psc_pkg::ST_OFF));
		wait_idle();
		check(selftest_fail_q, 1'b1);
		for (int k = 0; k < 4; k++) begin
			do_reset();
			id0 = 4'(2 * k + 1);
			id1 = 4'(2 * k + 2);
			// The data kinds are set before the sources are enabled.
			xfer(1'b1, psc_pkg::ADDR_KIND, {4'h0, 2'(k), psc_pkg::KIND_ABS},
				{4'h0, 2'(k), psc_pkg::KIND_ABS});
			xfer(1'b1, psc_pkg::ADDR_SRC0, {4'h8, id0}, {4'h8, id0});
			xfer(1'b1, psc_pkg::ADDR_SRC1, {4'h8, id1}, {4'h8, id1});
			// Odd passes run the digital test in range C, even passes in range B.
			xfer(1'b1, psc_pkg::ADDR_SPC, {3'h0, k[0], 4'h0}, {3'h0, k[0], 4'h0});
			xfer(1'b1, psc_pkg::ADDR_STSEL, 8'(psc_pkg::ST_DIG1 + k),
				8'(psc_pkg::ST_DIG1 + k));
			@(negedge clk_sys);
			check(selftest_running_q, 1'b1);
			stir();
			// Let the chain settle before frames are judged.
			repeat (4) @(negedge clk_sys);
			u_ctl.strobe(1'b1);
			check(frame_valid_q, 1'b0);
			xfer(1'b1, psc_pkg::ADDR_INIT, 8'hfe, 8'h00);
			check(pdcm_mode_q, 1'b0);
			if (k[0]) begin
				u_ctl.strobe(1'b0);
			end else begin
				xfer(1'b1, psc_pkg::ADDR_INIT, 8'h01, 8'h00);
			end
			check(pdcm_mode_q, 1'b1);
			u_ctl.crm(1'b0, 1'b0, psc_pkg::ADDR_SRC0, 8'h00);
			check(u_ctl.got, 1'b0);
			for (int j = 0; j < 4; j++) begin
				// Two fixed patterns first, so that every value bit of source 1 is seen in both states in passes 0, 2 and 3.
				if (j < 2) begin
					rel_pressure = j[0] ? 16'haaaa : 16'h5555;
					filt_pressure = rel_pressure;
					temperature = rel_pressure;
				end else begin
					stir();
				end
				want1 = k == 0 ? rel_pressure : k == 1 ? DW[k] : k == 2 ? filt_pressure
					: temperature;
				u_ctl.strobe(1'b1);
				check(frame_valid_q, 1'b1);
				check(frame_q, frame(id0, 2'(j), 4'hc, DW[k]));
				@(negedge clk_sys);
				check(frame_valid_q, 1'b1);
				check(frame_q, frame(id1, 2'(j), 4'hc, want1));
				@(negedge clk_sys);
				check(frame_valid_q, 1'b0);
			end
		end
		results();
	end
endmodule : pressure_satellite_config_selftest_test
